// >>> hw/codec_power_reset_softmute.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - soft mute ramps to full mute, 1024 frames
// - mute release ramps back to 0 dB
// - release mid-ramp returns at same rate
// - ramp 2048 frames double, 4096 quad
// - register mode: pump on per converter conditions
// - converter powers up after pump is ready
// - pin mode: registers ignored, pins control power
// - adc pin low resets adc registers, bit
// - dac pin low resets dac register, bit
// - both pins low: everything and pump down
// - after pin release in register mode all blocks stay down
// - power-down: dac output 0 V, adc data low
// - adc starts on master or frame rise
// - dac starts on frame rise, clocks present
// - adc data valid after 2640 frames
// - dac output held 0 V for init time
// - cleared power bit powers down, keeps registers
// - pump off only when both sides idle
// - adc reference settles 2048 frames after pump
// - auto speed uses master/frame ratio
module codec_power_reset_softmute #(
  parameter logic [codec_seq_pkg::PUMP_W-1:0] PUMP_UP_CYCLES = codec_seq_pkg::PUMP_UP_CYC,
  parameter logic [codec_seq_pkg::LOSS_W-1:0] CLK_LOSS_CYCLES = codec_seq_pkg::CLK_LOSS_CYC
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic adc_powerdown_pin_n_i,
  input wire logic dac_powerdown_pin_n_i,
  input wire logic reg_ctrl_mode_i,
  input wire logic adc_master_mode_i,
  input wire codec_seq_pkg::port_clocks_t adc_clocks_i,
  input wire codec_seq_pkg::port_clocks_t dac_clocks_i,
  input wire logic adc_serial_data_i,
  output logic adc_serial_out_o,
  output logic pump_enable_o,
  output logic adc_enable_o,
  output logic dac_enable_o,
  output logic dac_out_active_o,
  output logic [12:0] dac_mute_atten_o,
  output codec_seq_pkg::seq_status_t status_o
);
  import codec_seq_pkg::*;

  typedef struct packed {
    logic [5:0] clk_prev;
    logic [5:0][LOSS_W-1:0] idle_cnt;
    logic [7:0] reg_power;
    logic [7:0] reg_adc_input;
    logic [7:0] reg_adc_clock;
    logic [7:0] reg_dac_clock;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    seq_state_t adc_st;
    seq_state_t dac_st;
    logic [11:0] adc_cnt;
    logic [8:0] dac_cnt;
    logic [11:0] ref_cnt;
    logic ref_ok;
    logic [PUMP_W-1:0] pump_cnt;
    logic pump_ready;
    logic [10:0] ratio_cnt;
    speed_t auto_speed;
    logic [12:0] mute_level;
    logic sdo;
  } state_t;

  state_t s;
  state_t n;

  function automatic seq_state_t seq_step(input seq_state_t st, input logic req,
                                          input logic rdy, input logic go, input logic done);
    seq_step = st;
    if (!req)
    begin
      seq_step = S_OFF;
    end
    else
    begin
      unique case (st)
        S_OFF: seq_step = S_PUMP;
        S_PUMP: if (rdy) seq_step = S_START;
        S_START: if (go) seq_step = S_INIT;
        S_INIT: if (!rdy) seq_step = S_PUMP; else if (done) seq_step = S_RUN;
        S_RUN: if (!rdy) seq_step = S_PUMP;
        default: seq_step = S_OFF;
      endcase
    end
  endfunction : seq_step

  function automatic logic [12:0] ramp_step(input speed_t sp);
    unique case (sp)
      SPD_DOUBLE: ramp_step = 13'h0002;
      SPD_QUAD: ramp_step = 13'h0001;
      default: ramp_step = 13'h0004;
    endcase
  endfunction : ramp_step

  function automatic logic [8:0] dac_init_len(input speed_t sp);
    unique case (sp)
      SPD_DOUBLE: dac_init_len = DAC_INIT_DOUBLE;
      SPD_QUAD: dac_init_len = DAC_INIT_QUAD;
      default: dac_init_len = DAC_INIT_NORMAL;
    endcase
  endfunction : dac_init_len

  logic [5:0] clk_now;
  logic [5:0] clk_rise;
  logic [5:0] clk_active;
  logic adc_clk_ok;
  logic dac_clk_ok;
  logic adc_req;
  logic dac_req;
  logic pump_req;
  logic adc_go;
  logic dac_go;
  logic auto_sel;
  speed_t manual_speed;
  speed_t speed;
  logic bus_take;
  logic addr_ok;

  assign clk_now = {dac_clocks_i, adc_clocks_i};
  assign clk_rise = clk_now & ~s.clk_prev;

  generate
    for (genvar k = 0; k < 6; k++)
    begin : g_act
      assign clk_active[k] = s.idle_cnt[k] < CLK_LOSS_CYCLES;
    end
  endgenerate

  // in master mode the adc port only needs its master clock
  assign adc_clk_ok = adc_master_mode_i ? clk_active[CLK_MASTER_POS] : &clk_active[2:0];
  assign dac_clk_ok = &clk_active[5:3];
  // pin mode ignores the power bits, so a high pin alone asks for power
  assign adc_req = adc_powerdown_pin_n_i &
                   (~reg_ctrl_mode_i | s.reg_power[ADC_PWR_POS]);
  assign dac_req = dac_powerdown_pin_n_i &
                   (~reg_ctrl_mode_i | s.reg_power[DAC_PWR_POS]);
  // pump stays up while either side asks; off only when both are idle
  assign pump_req = (adc_req & adc_clk_ok) | (dac_req & dac_clk_ok);
  assign adc_go = adc_master_mode_i ? clk_rise[CLK_MASTER_POS] :
                  (adc_clk_ok & clk_rise[CLK_FRAME_POS]);
  assign dac_go = dac_clk_ok & clk_rise[3 + CLK_FRAME_POS];

  always_comb
  begin
    unique case (s.reg_dac_clock[DFS_POS+1:DFS_POS])
      2'b01: manual_speed = SPD_DOUBLE;
      2'b10: manual_speed = SPD_QUAD;
      default: manual_speed = SPD_NORMAL;
    endcase
  end

  // pin mode has no speed field, so it always detects the speed
  assign auto_sel = ~reg_ctrl_mode_i | s.reg_dac_clock[AUTO_SPEED_SELECT_BIT_POS];
  assign speed = auto_sel ? s.auto_speed : manual_speed;

  assign bus_take = hsel_i & hready_i & htrans_i[1];
  assign addr_ok = (haddr_i[31:10] == 22'h00_0000) & (haddr_i[1:0] == 2'b00);

  always_comb
  begin
    n = s;
    n.clk_prev = clk_now;
    for (int k = 0; k < 6; k++)
    begin
      if (clk_now[k] != s.clk_prev[k])
      begin
        n.idle_cnt[k] = '0;
      end
      else if (s.idle_cnt[k] < CLK_LOSS_CYCLES)
      begin
        n.idle_cnt[k] = s.idle_cnt[k] + LOSS_W'(1);
      end
    end

    // data phase of a write
    n.wr_pend = 1'b0;
    if (s.wr_pend)
    begin
      unique case (s.wr_idx)
        IDX_POWER: n.reg_power = hwdata_i[7:0] & POWER_MASK;
        IDX_ADC_INPUT: n.reg_adc_input = hwdata_i[7:0] & ADC_INPUT_MASK;
        IDX_ADC_CLOCK: n.reg_adc_clock = hwdata_i[7:0] & ADC_CLOCK_MASK;
        IDX_DAC_CLOCK: n.reg_dac_clock = hwdata_i[7:0] & DAC_CLOCK_MASK;
        default: n.wr_pend = 1'b0;
      endcase
    end

    // a low pin wins over a write in the same cycle
    if (!adc_powerdown_pin_n_i)
    begin
      n.reg_adc_input = ADC_INPUT_RST;
      n.reg_adc_clock = ADC_CLOCK_RST;
      n.reg_power[ADC_PWR_POS] = POWER_RST[ADC_PWR_POS];
    end
    if (!dac_powerdown_pin_n_i)
    begin
      n.reg_dac_clock = DAC_CLOCK_RST;
      n.reg_power[DAC_PWR_POS] = POWER_RST[DAC_PWR_POS];
    end

    // address phase; read data comes from the updated copy so that
    // a read right behind a write sees the new value
    if (bus_take)
    begin
      n.wr_pend = hwrite_i & addr_ok;
      n.wr_idx = haddr_i[9:2];
      n.rdata = 32'h0000_0000;
      if (!hwrite_i && addr_ok)
      begin
        unique case (haddr_i[9:2])
          IDX_POWER: n.rdata[7:0] = n.reg_power;
          IDX_ADC_INPUT: n.rdata[7:0] = n.reg_adc_input;
          IDX_ADC_CLOCK: n.rdata[7:0] = n.reg_adc_clock;
          IDX_DAC_CLOCK: n.rdata[7:0] = n.reg_dac_clock;
          IDX_STATUS: n.rdata[7:0] = status_o;
          default: n.rdata = 32'h0000_0000;
        endcase
      end
    end

    // charge pump power-up timer and adc reference settling
    if (!pump_req)
    begin
      n.pump_cnt = '0;
      n.pump_ready = 1'b0;
      n.ref_cnt = '0;
      n.ref_ok = 1'b0;
    end
    else
    begin
      if (!s.pump_ready)
      begin
        n.pump_cnt = s.pump_cnt + PUMP_W'(1);
        n.pump_ready = (s.pump_cnt + PUMP_W'(1)) >= PUMP_UP_CYCLES;
      end
      if (s.pump_ready && !s.ref_ok && clk_rise[CLK_FRAME_POS])
      begin
        n.ref_cnt = s.ref_cnt + 12'h001;
        n.ref_ok = (s.ref_cnt + 12'h001) >= REF_SETTLE_FRAMES;
      end
    end

    // converter sequences: off, wait for pump, wait for start edge, init, run
    n.adc_st = seq_step(s.adc_st, adc_req, s.pump_ready, adc_go,
                        (s.adc_cnt >= ADC_INIT_FRAMES) & s.ref_ok);
    n.dac_st = seq_step(s.dac_st, dac_req, s.pump_ready, dac_go,
                        s.dac_cnt >= dac_init_len(speed));
    if (n.adc_st != S_INIT)
    begin
      n.adc_cnt = '0;
    end
    else if (clk_rise[CLK_FRAME_POS] && s.adc_cnt < ADC_INIT_FRAMES)
    begin
      n.adc_cnt = s.adc_cnt + 12'h001;
    end
    if (n.dac_st != S_INIT)
    begin
      n.dac_cnt = '0;
    end
    else if (clk_rise[3 + CLK_FRAME_POS] && s.dac_cnt < DAC_INIT_QUAD)
    begin
      n.dac_cnt = s.dac_cnt + 9'h001;
    end

    // master clocks per frame period pick the speed
    if (clk_rise[3 + CLK_FRAME_POS])
    begin
      n.ratio_cnt = {10'h000, clk_rise[3 + CLK_MASTER_POS]};
      if (s.ratio_cnt >= RATIO_NORMAL_MIN)
      begin
        n.auto_speed = SPD_NORMAL;
      end
      else if (s.ratio_cnt >= RATIO_DOUBLE_MIN)
      begin
        n.auto_speed = SPD_DOUBLE;
      end
      else
      begin
        n.auto_speed = SPD_QUAD;
      end
    end
    else if (clk_rise[3 + CLK_MASTER_POS] && s.ratio_cnt != 11'h7FF)
    begin
      n.ratio_cnt = s.ratio_cnt + 11'h001;
    end

    // soft mute: the level moves one step per dac frame in either direction,
    // so a release part way down climbs back at the rate it fell
    if (!dac_powerdown_pin_n_i)
    begin
      n.mute_level = '0;
    end
    else if (clk_rise[3 + CLK_FRAME_POS])
    begin
      if (reg_ctrl_mode_i && s.reg_dac_clock[SOFT_MUTE_BIT_POS])
      begin
        if (MUTE_FULL - s.mute_level > ramp_step(speed))
        begin
          n.mute_level = s.mute_level + ramp_step(speed);
        end
        else
        begin
          n.mute_level = MUTE_FULL;
        end
      end
      else if (s.mute_level > ramp_step(speed))
      begin
        n.mute_level = s.mute_level - ramp_step(speed);
      end
      else
      begin
        n.mute_level = '0;
      end
    end

    // adc data is forced low until the converter runs
    n.sdo = adc_serial_data_i & (s.adc_st == S_RUN);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s <= '{clk_prev: '0,
             idle_cnt: {6{CLK_LOSS_CYCLES}},
             reg_power: POWER_RST,
             reg_adc_input: ADC_INPUT_RST,
             reg_adc_clock: ADC_CLOCK_RST,
             reg_dac_clock: DAC_CLOCK_RST,
             wr_pend: 1'b0,
             wr_idx: '0,
             rdata: '0,
             adc_st: S_OFF,
             dac_st: S_OFF,
             adc_cnt: '0,
             dac_cnt: '0,
             ref_cnt: '0,
             ref_ok: 1'b0,
             pump_cnt: '0,
             pump_ready: 1'b0,
             ratio_cnt: '0,
             auto_speed: SPD_NORMAL,
             mute_level: '0,
             sdo: 1'b0};
    end
    else
    begin
      s <= n;
    end
  end

  // zero-wait slave; every access answers OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s.rdata;

  assign adc_serial_out_o = s.sdo;
  assign pump_enable_o = s.pump_cnt != '0 || s.pump_ready;
  assign adc_enable_o = s.adc_st == S_INIT || s.adc_st == S_RUN;
  assign dac_enable_o = s.dac_st == S_INIT || s.dac_st == S_RUN;
  // analog output stays at 0 V while down or initializing
  assign dac_out_active_o = s.dac_st == S_RUN;
  assign dac_mute_atten_o = s.mute_level;

  assign status_o.pump_on = pump_enable_o;
  assign status_o.pump_ready = s.pump_ready;
  assign status_o.ref_ok = s.ref_ok;
  assign status_o.adc_run = s.adc_st == S_RUN;
  assign status_o.dac_run = s.dac_st == S_RUN;
  assign status_o.mute_full = s.mute_level == MUTE_FULL;
  assign status_o.speed = speed;
endmodule : codec_power_reset_softmute
`default_nettype wire

// >>> hw/codec_seq_pkg.sv
`default_nettype none
package codec_seq_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int PUMP_UP_NS = 1300000;
  localparam int PUMP_W = 20;
  localparam logic [PUMP_W-1:0] PUMP_UP_CYC =
    PUMP_W'((PUMP_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // a port clock counts as absent after this long without a level change
  localparam int CLK_LOSS_NS = 40000;
  localparam int LOSS_W = 14;
  localparam logic [LOSS_W-1:0] CLK_LOSS_CYC = LOSS_W'(CLK_LOSS_NS / CLK_PERIOD_NS);
  // frame-clock counts, full mute level and master clocks per frame limits
  localparam logic [11:0] ADC_INIT_FRAMES = 12'h0A50;
  localparam logic [11:0] REF_SETTLE_FRAMES = 12'h0800;
  localparam logic [8:0] DAC_INIT_NORMAL = 9'h060;
  localparam logic [8:0] DAC_INIT_DOUBLE = 9'h0C0;
  localparam logic [8:0] DAC_INIT_QUAD = 9'h180;
  localparam logic [12:0] MUTE_FULL = 13'h1000;
  localparam logic [10:0] RATIO_NORMAL_MIN = 11'h1C0;
  localparam logic [10:0] RATIO_DOUBLE_MIN = 11'h0E0;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_POWER = 8'h00;
  localparam logic [7:0] IDX_ADC_INPUT = 8'h01;
  localparam logic [7:0] IDX_ADC_CLOCK = 8'h02;
  localparam logic [7:0] IDX_DAC_CLOCK = 8'h03;
  localparam logic [7:0] IDX_STATUS = 8'h08;
  // field positions
  localparam int ADC_PWR_POS = 0;
  localparam int DAC_PWR_POS = 1;
  localparam int SOFT_MUTE_BIT_POS = 0;
  localparam int DFS_POS = 4;
  localparam int AUTO_SPEED_SELECT_BIT_POS = 6;
  localparam int CLK_BIT_POS = 0;
  localparam int CLK_FRAME_POS = 1;
  localparam int CLK_MASTER_POS = 2;
  // writable masks and reset values
  localparam logic [7:0] POWER_MASK = 8'h03;
  localparam logic [7:0] ADC_INPUT_MASK = 8'h03;
  localparam logic [7:0] ADC_CLOCK_MASK = 8'h16;
  localparam logic [7:0] DAC_CLOCK_MASK = 8'h7F;
  localparam logic [7:0] POWER_RST = 8'h00;
  localparam logic [7:0] ADC_INPUT_RST = 8'h00;
  localparam logic [7:0] ADC_CLOCK_RST = 8'h00;
  localparam logic [7:0] DAC_CLOCK_RST = 8'h04;

  typedef struct packed {
    logic master;
    logic frame;
    logic bitclk;
  } port_clocks_t;

  typedef enum logic [1:0] {
    SPD_NORMAL = 2'b00,
    SPD_DOUBLE = 2'b01,
    SPD_QUAD = 2'b10
  } speed_t;

  typedef enum logic [2:0] {
    S_OFF = 3'b000,
    S_PUMP = 3'b001,
    S_START = 3'b010,
    S_INIT = 3'b011,
    S_RUN = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic pump_on;
    logic pump_ready;
    logic ref_ok;
    logic adc_run;
    logic dac_run;
    logic mute_full;
    speed_t speed;
  } seq_status_t;
endpackage : codec_seq_pkg
`default_nettype wire

// >>> testbench/codec_seq_chk.sv
`timescale 1ns/10ps
`default_nettype none
module codec_seq_chk #(
  parameter logic [codec_seq_pkg::PUMP_W-1:0] PUMP_UP_CYCLES = codec_seq_pkg::PUMP_UP_CYC
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic adc_powerdown_pin_n_i,
  input wire logic dac_powerdown_pin_n_i,
  input wire logic adc_serial_out_o,
  input wire logic pump_enable_o,
  input wire logic adc_enable_o,
  input wire logic dac_enable_o,
  input wire logic dac_out_active_o,
  input wire logic [12:0] dac_mute_atten_o,
  input wire codec_seq_pkg::seq_status_t status_o
);
  import codec_seq_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // length of the current unbroken pump-on stretch, saturating
  logic [PUMP_W-1:0] on_cnt;
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      on_cnt <= '0;
    else if (!pump_enable_o)
      on_cnt <= '0;
    else if (on_cnt != '1)
      on_cnt <= on_cnt + 1'b1;
  end
  // a low pin acts at the next edge; five low cycles leave margin for
  // the sequencer and the mute level to have dropped
  sequence adc_low_s;
    !adc_powerdown_pin_n_i [*5];
  endsequence
  sequence dac_low_s;
    !dac_powerdown_pin_n_i [*5];
  endsequence
  sequence both_low_s;
    (!adc_powerdown_pin_n_i && !dac_powerdown_pin_n_i) [*5];
  endsequence
  adc_pin_a: assert property (adc_low_s |-> !adc_enable_o && !status_o.adc_run)
    else $error("adc on with its pin low");
  dac_pin_a: assert property (dac_low_s |-> !dac_enable_o && dac_mute_atten_o == '0)
    else $error("dac on or mute kept with its pin low");
  both_pin_a: assert property (both_low_s |-> !pump_enable_o && !status_o.pump_ready)
    else $error("pump on with both pins low");
  pump_first_a: assert property ($rose(adc_enable_o) || $rose(dac_enable_o)
    |-> status_o.pump_ready)
    else $error("converter up before pump ready");
  pump_time_a: assert property ($rose(status_o.pump_ready)
    |-> on_cnt >= PUMP_UP_CYCLES - 1)
    else $error("pump ready too early");
  adc_quiet_a: assert property (!adc_enable_o ##1 !adc_enable_o |-> !adc_serial_out_o)
    else $error("adc data not low while down");
  // init spans many frames, so an active output must follow a long enable
  dac_zero_a: assert property (dac_out_active_o
    |-> dac_enable_o && status_o.dac_run && $past(dac_enable_o, 8))
    else $error("dac output active while not running");
  mute_step_a: assert property (dac_mute_atten_o > $past(dac_mute_atten_o)
    |-> dac_mute_atten_o - $past(dac_mute_atten_o) <= 13'h4 && dac_mute_atten_o <= MUTE_FULL)
    else $error("mute ramp step too large");
  adc_run_a: assert property ($rose(status_o.adc_run) |-> status_o.ref_ok && adc_enable_o)
    else $error("adc running before reference settled");
endmodule : codec_seq_chk
bind codec_power_reset_softmute codec_seq_chk #(.PUMP_UP_CYCLES(PUMP_UP_CYCLES)) chk_i (
  .core_clk_i(core_clk_i),
  .arst_n_i(arst_n_i),
  .adc_powerdown_pin_n_i(adc_powerdown_pin_n_i),
  .dac_powerdown_pin_n_i(dac_powerdown_pin_n_i),
  .adc_serial_out_o(adc_serial_out_o),
  .pump_enable_o(pump_enable_o),
  .adc_enable_o(adc_enable_o),
  .dac_enable_o(dac_enable_o),
  .dac_out_active_o(dac_out_active_o),
  .dac_mute_atten_o(dac_mute_atten_o),
  .status_o(status_o)
);
`default_nettype wire

// >>> testbench/codec_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module codec_host_model (
  input wire logic core_clk_i,
  input wire logic supply_ok_i,
  input wire logic adc_req_i,
  input wire logic dac_req_i,
  input wire logic adc_on_i,
  input wire logic dac_on_i,
  output logic adc_pin_n_o,
  output logic dac_pin_n_o,
  output codec_seq_pkg::port_clocks_t adc_clk_o,
  output codec_seq_pkg::port_clocks_t dac_clk_o
);
  import codec_seq_pkg::*;
  // 150 ns of low time at 4 ns a cycle, rounded up
  localparam int LOW_MIN = 38;
  int adc_low = 0;
  int dac_low = 0;
  logic [2:0] adc_cnt = '0;
  logic [2:0] dac_cnt = '0;
  initial adc_pin_n_o = 1'b0;
  initial dac_pin_n_o = 1'b0;
  always @(posedge core_clk_i)
  begin
    adc_low <= adc_pin_n_o ? 0 : adc_low + 1;
    dac_low <= dac_pin_n_o ? 0 : dac_low + 1;
    adc_pin_n_o <= supply_ok_i && adc_req_i &&
                   (adc_pin_n_o || adc_low >= LOW_MIN);
    dac_pin_n_o <= supply_ok_i && dac_req_i &&
                   (dac_pin_n_o || dac_low >= LOW_MIN);
    // stopped clocks hold their level rather than run free
    if (adc_on_i)
      adc_cnt <= adc_cnt + 3'h1;
    if (dac_on_i)
      dac_cnt <= dac_cnt + 3'h1;
  end
  assign adc_clk_o = {adc_cnt[0], adc_cnt[2], adc_cnt[1]};
  assign dac_clk_o = {dac_cnt[0], dac_cnt[2], dac_cnt[1]};
endmodule : codec_host_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import codec_seq_pkg::*;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hready, hresp, rd_pend = 1'b0;
  logic [31:0] hrdata;
  logic supply_ok = 1'b0, adc_req = 1'b0, dac_req = 1'b0, adc_on = 1'b0, dac_on = 1'b0;
  logic reg_mode = 1'b1, master_mode = 1'b0, adc_data = 1'b0, prev_d = 1'b0;
  logic adc_pin_n, dac_pin_n, ser_out, pump, adc_en, dac_en, dac_act;
  logic [12:0] atten;
  port_clocks_t adc_clk, dac_clk;
  seq_status_t st;
  logic [31:0] seed = 32'hcf8c_89fc;
  logic [31:0] r;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int checked = 0;
  codec_host_model codec_host_model_i (.core_clk_i(core_clk), .supply_ok_i(supply_ok),
    .adc_req_i(adc_req), .dac_req_i(dac_req), .adc_on_i(adc_on), .dac_on_i(dac_on),
    .adc_pin_n_o(adc_pin_n), .dac_pin_n_o(dac_pin_n), .adc_clk_o(adc_clk), .dac_clk_o(dac_clk));
  codec_power_reset_softmute #(.PUMP_UP_CYCLES(20'h0_0014), .CLK_LOSS_CYCLES(14'h0010))
    codec_power_reset_softmute_i (.core_clk_i(core_clk), .arst_n_i(arst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .adc_powerdown_pin_n_i(adc_pin_n), .dac_powerdown_pin_n_i(dac_pin_n),
    .reg_ctrl_mode_i(reg_mode), .adc_master_mode_i(master_mode), .adc_clocks_i(adc_clk),
    .dac_clocks_i(dac_clk), .adc_serial_data_i(adc_data), .adc_serial_out_o(ser_out),
    .pump_enable_o(pump), .adc_enable_o(adc_en), .dac_enable_o(dac_en),
    .dac_out_active_o(dac_act), .dac_mute_atten_o(atten), .status_o(st));
  initial forever #2 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction : ad
  function automatic logic [31:0] b1(input logic x);
    return {31'h0, x};
  endfunction : b1
  task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string m);
    checked++;
    if (act !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, act, exp);
    end
  endtask : chk
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
  endtask : ahb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(a, 1'b0, ZERO);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle
  task automatic frames(input int n);
    repeat (n) @(posedge dac_clk.frame);
    @(negedge core_clk);
  endtask : frames
  task automatic stop_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  always @(posedge core_clk)
  begin
    seed <= xs(seed);
    prev_d <= adc_data;
    adc_data <= seed[0];
  end
  // read data is compared against the oldest note left by the read task
  always @(posedge core_clk)
  begin
    if (rd_pend && hready === 1'b1)
    begin
      chk(hrdata, exp_q.pop_front(), "read data");
      chk(b1(hresp), ZERO, "response not okay");
    end
    rd_pend <= htrans[1] && !hwrite && hready;
  end
  initial
  begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    supply_ok <= 1'b1;
    rd(ad(IDX_POWER), POWER_RST);
    rd(ad(IDX_ADC_CLOCK), ADC_CLOCK_RST);
    rd(ad(IDX_DAC_CLOCK), DAC_CLOCK_RST);
    rd(ad(8'h04), ZERO);
    wr(ad(IDX_ADC_INPUT), 32'h0000_0003);
    rd(ad(IDX_ADC_INPUT), ADC_INPUT_RST);
    adc_req <= 1'b1;
    dac_req <= 1'b1;
    settle(50);
    r = seed;
    wr(ad(IDX_POWER), 32'h0000_0003);
    wr(ad(IDX_ADC_INPUT), r);
    rd(ad(IDX_ADC_INPUT), r & ADC_INPUT_MASK);
    wr(ad(IDX_ADC_CLOCK), 32'hffff_ffff);
    rd(ad(IDX_ADC_CLOCK), ADC_CLOCK_MASK);
    settle(40);
    chk(b1(pump), ZERO, "pump without clocks");
    adc_on <= 1'b1;
    dac_on <= 1'b1;
    settle(40);
    chk(b1(pump), ONE, "pump with clocks");
    frames(88);
    chk(b1(dac_act), ZERO, "dac output during init");
    chk(b1(ser_out), ZERO, "adc data during init");
    frames(12);
    chk(b1(dac_act), ONE, "dac running");
    wr(ad(IDX_DAC_CLOCK), 32'h0000_0005);
    frames(1018);
    chk(b1(st.mute_full), ZERO, "mute early");
    frames(10);
    chk(b1(st.mute_full), ONE, "mute full flag");
    chk(atten, MUTE_FULL, "mute level");
    wr(ad(IDX_DAC_CLOCK), 32'h0000_0004);
    frames(1018);
    chk(b1(atten == '0), ZERO, "release early");
    frames(10);
    chk(atten, ZERO, "released");
    chk(b1(st.adc_run), ZERO, "adc still in init");
    wr(ad(IDX_DAC_CLOCK), 32'h0000_0005);
    frames(300);
    wr(ad(IDX_DAC_CLOCK), 32'h0000_0004);
    frames(290);
    chk(b1(atten == '0), ZERO, "mid-ramp release early");
    frames(16);
    chk(atten, ZERO, "mid-ramp released");
    chk(b1(st.adc_run), ONE, "adc running");
    chk(b1(ser_out), b1(prev_d), "adc data");
    wr(ad(IDX_DAC_CLOCK), 32'h0000_0015);
    frames(2040);
    chk(b1(st.mute_full), ZERO, "double mute early");
    frames(16);
    chk(atten, MUTE_FULL, "double mute level");
    chk(st.speed, SPD_DOUBLE, "manual speed");
    wr(ad(IDX_POWER), 32'h0000_0002);
    settle(8);
    chk(b1(adc_en), ZERO, "adc bit cleared");
    chk(b1(ser_out), ZERO, "adc data low");
    rd(ad(IDX_ADC_INPUT), r & ADC_INPUT_MASK);
    dac_req <= 1'b0;
    settle(8);
    chk(b1(dac_en), ZERO, "dac pin low");
    chk(atten, ZERO, "mute level cleared");
    chk(b1(pump), ZERO, "pump both idle");
    rd(ad(IDX_DAC_CLOCK), DAC_CLOCK_RST);
    rd(ad(IDX_POWER), POWER_RST);
    rd(ad(IDX_ADC_CLOCK), ADC_CLOCK_MASK);
    reg_mode <= 1'b0;
    dac_req <= 1'b1;
    settle(70);
    chk(b1(pump), ONE, "pin mode pump");
    frames(8);
    chk(b1(dac_en), ONE, "pin mode dac");
    chk(st.speed, SPD_QUAD, "auto speed");
    adc_req <= 1'b0;
    dac_req <= 1'b0;
    settle(10);
    chk(b1(pump), ZERO, "both pins low");
    rd(ad(IDX_ADC_CLOCK), ADC_CLOCK_RST);
    reg_mode <= 1'b1;
    adc_req <= 1'b1;
    dac_req <= 1'b1;
    settle(70);
    chk(b1(adc_en | dac_en | pump), ZERO, "all down after release");
    wr(ad(IDX_POWER), 32'h0000_0001);
    master_mode <= 1'b1;
    settle(60);
    chk(b1(adc_en), ONE, "master mode adc start");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
